// File: rtl/slot_buffer.sv
// two-entry buffer between the selector and the high-speed line
module slot_buffer (
   input  wire logic                 clk_i,
   input  wire logic                 nrst_i,
   input  wire logic                 in_valid_i,
   output logic                      in_ready_o,
   input  wire tdm_sel_pkg::slot_t   in_slot_i,
   output logic                      out_valid_o,
   input  wire logic                 out_ready_i,
   output tdm_sel_pkg::slot_t        out_slot_o
);
   logic                 skid_valid_ff;
   tdm_sel_pkg::slot_t   skid_slot_ff;
   logic                 out_valid_ff;
   tdm_sel_pkg::slot_t   out_slot_ff;

   // handshake decode
   wire  push      = in_valid_i & ~skid_valid_ff;
   wire  pop       = out_valid_ff & out_ready_i;
   wire  head_free = ~out_valid_ff | out_ready_i;

   // head register feeds the line, skid catches a word during a stall
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         out_valid_ff  <= 1'b0;
         skid_valid_ff <= 1'b0;
         out_slot_ff   <= '0;
         skid_slot_ff  <= '0;
      end else begin
         if (head_free) begin
            out_valid_ff <= skid_valid_ff | push;
            out_slot_ff  <= skid_valid_ff ? skid_slot_ff : in_slot_i;
         end
         if (head_free) begin
            skid_valid_ff <= 1'b0;
         end else if (push) begin
            skid_valid_ff <= 1'b1;
            skid_slot_ff  <= in_slot_i;
         end
      end
   end

   assign in_ready_o  = ~skid_valid_ff;
   assign out_valid_o = out_valid_ff;
   assign out_slot_o  = out_slot_ff;

   stall_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      out_valid_o && !out_ready_i |=> out_valid_o && $stable(out_slot_o))
      else $error("buffered slot changed during stall");
   full_stall_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      out_valid_o && !out_ready_i && in_valid_i ##1 !out_ready_i |=> !in_ready_o)
      else $error("buffer kept accepting while full");
   skid_drain_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      skid_valid_ff && head_free |=> out_valid_o && out_slot_o == $past(skid_slot_ff))
      else $error("held word did not move to the head");
endmodule : slot_buffer

// File: rtl/tdm_channel_selector.sv
// thirty-two channel time slot selector with counter or external select
// What this block does
// - every channel gets exactly one slot per multiplexing cycle while load is low
// - a slot carries only the selected channel's data
// - slot order repeats identically each cycle under sequential selection
// - bit-interleaved: one slot is one bit period, one bit
// - character-interleaved: whole character passes before the channel advances
// - statistical: outside party picks active channels, slot length varies
// - output driven from one of 32 inputs by a 32-way select network
// - internal counter supplies the select code for sequential operation
// - two-way choice between counter and external select code
// - thirty-nine pin inputs, five counter registers, one output line
// - load low: 5-bit counter steps through inputs and selects
// - load high: external code selects and is loaded into counter
// - load takes effect once it has passed the two-stage synchroniser, two clock edges later
module tdm_channel_selector (
   input  wire logic                                  clk_i,
   input  wire logic                                  nrst_i,
   input  wire logic [tdm_sel_pkg::CHAN_COUNT-1:0]    chan_data_i,
   input  wire logic [tdm_sel_pkg::SEL_W-1:0]         chan_addr_i,
   input  wire logic                                  select_source_load_i,
   input  wire logic                                  char_mode_i,
   input  wire logic                                  line_ready_i,
   output logic                                       line_valid_o,
   output tdm_sel_pkg::slot_t                         line_slot_o
);
   tdm_sel_pkg::pins_t                  sync1_ff;
   tdm_sel_pkg::pins_t                  sync2_ff;
   logic [tdm_sel_pkg::SEL_W-1:0]       cnt_ff;
   logic [tdm_sel_pkg::BITCNT_W-1:0]    bit_ff;
   logic [tdm_sel_pkg::SEL_W-1:0]       nxt_cnt;
   logic [tdm_sel_pkg::BITCNT_W-1:0]    nxt_bit;
   logic                                buf_ready;
   logic [1:0]                          prime_ff;
   logic                                primed;
   tdm_sel_pkg::slot_t                  cur_slot;

   // two-stage synchroniser on every pin input
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
      end else begin
         sync1_ff <= {chan_data_i, chan_addr_i, select_source_load_i, char_mode_i};
         sync2_ff <= sync1_ff;
      end
   end

   // holds the selector off until both synchroniser stages carry pin values;
   // without it the first slots after reset would carry the flushed zeros
   // instead of the channel's bit and would ignore the mode and load pins
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         prime_ff <= 2'h0;
      end else begin
         prime_ff <= {prime_ff[0], 1'b1};
      end
   end

   assign primed = prime_ff[1];

   // select source and slot framing
   wire                                 load      = sync2_ff.load;
   wire [tdm_sel_pkg::SEL_W-1:0]        ext_addr  = sync2_ff.addr;
   wire [tdm_sel_pkg::SEL_W-1:0]        sel       = load ? ext_addr : cnt_ff;
   wire                                 sel_bit   = sync2_ff.data[sel];
   wire                                 char_end  = bit_ff == tdm_sel_pkg::CHAR_LAST;
   wire                                 slot_end  = ~sync2_ff.char_mode | char_end;
   wire                                 take      = buf_ready & primed;
   wire                                 advance   = take & ~load & slot_end;

   // slot word handed to the buffer
   assign cur_slot.chan  = sel;
   assign cur_slot.first = (bit_ff == tdm_sel_pkg::BITCNT_RST);
   assign cur_slot.data  = sel_bit;

   // next counter and bit position
   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_bit = bit_ff;
      if (load) begin
         nxt_cnt = ext_addr;
         if (take) begin
            nxt_bit = slot_end ? tdm_sel_pkg::BITCNT_RST : bit_ff + tdm_sel_pkg::BIT_STEP;
         end
      end else if (take) begin
         if (slot_end) begin
            nxt_cnt = tdm_sel_pkg::next_chan(cnt_ff);
            nxt_bit = tdm_sel_pkg::BITCNT_RST;
         end else begin
            nxt_bit = bit_ff + tdm_sel_pkg::BIT_STEP;
         end
      end
   end

   // five counter flops plus in-character bit position
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         cnt_ff <= tdm_sel_pkg::CNT_RST;
         bit_ff <= tdm_sel_pkg::BITCNT_RST;
      end else begin
         cnt_ff <= nxt_cnt;
         bit_ff <= nxt_bit;
      end
   end

   // buffer so a stalled line loses no slot
   slot_buffer u_buf (
      .clk_i       (clk_i),
      .nrst_i      (nrst_i),
      .in_valid_i  (primed),
      .in_ready_o  (buf_ready),
      .in_slot_i   (cur_slot),
      .out_valid_o (line_valid_o),
      .out_ready_i (line_ready_i),
      .out_slot_o  (line_slot_o)
   );

   wrap_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      cnt_ff == tdm_sel_pkg::CNT_LAST && advance |=> cnt_ff == tdm_sel_pkg::CNT_RST)
      else $error("counter did not wrap to channel 0");
   step_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      advance |=> cnt_ff == $past(cnt_ff) + tdm_sel_pkg::CNT_STEP)
      else $error("counter did not step by one");
   load_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      load |=> cnt_ff == $past(ext_addr))
      else $error("external code not loaded into counter");
   source_sel_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      cur_slot.chan == (load ? ext_addr : cnt_ff))
      else $error("wrong select source");
   slot_data_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      take |-> cur_slot.data == sync2_ff.data[cur_slot.chan])
      else $error("slot carries another channel's data");
   char_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      sync2_ff.char_mode && take && !char_end && !load |=> $stable(cnt_ff))
      else $error("channel advanced inside a character");
   bit_slot_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !sync2_ff.char_mode && take && !load |=> cnt_ff != $past(cnt_ff))
      else $error("bit slot lasted more than one bit");
   cycle_repeat_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      (advance && !sync2_ff.char_mode) [*8] |=> cnt_ff == $past(cnt_ff, 8) + 5'h08)
      else $error("slot order broke within a cycle");

   // nothing reaches the line before the synchroniser is filled
   prime_quiet_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !primed |-> !line_valid_o)
      else $error("slot offered before pins were synchronised");

   // second synchroniser stage copies the first
   sync_pipe_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      sync2_ff == $past(sync1_ff))
      else $error("synchroniser stage skipped");

   // bit slots never leave a bit position behind
   bit_pos_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !sync2_ff.char_mode && take |=> bit_ff == tdm_sel_pkg::BITCNT_RST)
      else $error("bit slot kept a bit position");

   // inside a character the bit position steps by one
   char_step_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      sync2_ff.char_mode && take && !char_end |=> bit_ff == $past(bit_ff) + 3'h1)
      else $error("bit position did not step inside a character");

   // the last bit of a character closes the slot
   char_close_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      take && char_end |=> bit_ff == tdm_sel_pkg::BITCNT_RST)
      else $error("character slot did not close after its last bit");

   // a full buffer freezes counter and bit position while load is low
   stall_freeze_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !take && !load |=> $stable(cnt_ff) && $stable(bit_ff))
      else $error("selector moved while no slot was taken");

   // a held external code keeps the bit position while stalled
   load_freeze_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      load && !take |=> $stable(bit_ff))
      else $error("bit position moved during a stalled load");

   // external code drives the selection while loading
   load_sel_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      load |-> cur_slot.chan == ext_addr)
      else $error("loaded code not used as select");

   // counter selects while not loading
   cnt_sel_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !load |-> cur_slot.chan == cnt_ff)
      else $error("counter not used as select");

   // channel stays put while a character is still running
   mid_char_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      !load && take && !slot_end |=> $stable(cnt_ff))
      else $error("channel left before its slot ended");

   // the line word stands while the receiver stalls
   line_hold_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      line_valid_o && !line_ready_i |=> line_valid_o && $stable(line_slot_o))
      else $error("line word changed during a stall");

   // every taken slot reaches the line on the next edge when the head is free
   line_fill_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      take && (!line_valid_o || line_ready_i) |=> line_valid_o)
      else $error("taken slot did not reach the line");

   // the first flag marks bit position zero only
   first_flag_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      cur_slot.first == (bit_ff == tdm_sel_pkg::BITCNT_RST))
      else $error("first flag off its bit position");

   // counter moves on in character mode once the last bit of the character is taken
   char_cnt_a: assert property (@(posedge clk_i) disable iff (!nrst_i)
      sync2_ff.char_mode && !load && take && char_end |=> cnt_ff != $past(cnt_ff))
      else $error("channel did not advance after a character");
endmodule : tdm_channel_selector

// File: rtl/tdm_sel_pkg.sv
// shared constants and carrier types for the channel selector
package tdm_sel_pkg;
   localparam int          CHAN_COUNT = 32;   // low-speed channel inputs
   localparam int          SEL_W      = 5;    // width of the select code
   localparam int          BITCNT_W   = 3;    // width of the in-character bit counter
   localparam int          SYNC_W     = 39;   // data, select code, load, mode
   localparam logic [SEL_W-1:0]    CNT_RST    = 5'h00;  // counter after reset
   localparam logic [SEL_W-1:0]    CNT_LAST   = 5'h1f;  // last channel before wrap
   localparam logic [SEL_W-1:0]    CNT_STEP   = 5'h01;  // counter increment
   localparam logic [BITCNT_W-1:0] BITCNT_RST = 3'h0;   // bit counter after reset
   localparam logic [BITCNT_W-1:0] CHAR_LAST  = 3'h7;   // last bit of an 8-bit character
   localparam logic [BITCNT_W-1:0] BIT_STEP   = 3'h1;   // bit counter increment

   // one slot word on the high-speed line
   typedef struct packed {
      logic [SEL_W-1:0] chan;      // channel that owns the slot
      logic             first;     // first bit of a slot
      logic             data;      // the channel's bit
   } slot_t;

   localparam int SLOT_W = $bits(slot_t);

   // pin group after synchronising
   typedef struct packed {
      logic [CHAN_COUNT-1:0] data;
      logic [SEL_W-1:0]      addr;
      logic                  load;
      logic                  char_mode;
   } pins_t;

   // select counter advance with wrap from the last channel to channel 0
   function automatic logic [SEL_W-1:0] next_chan(input logic [SEL_W-1:0] c);
      next_chan = (c == CNT_LAST) ? CNT_RST : c + CNT_STEP;
   endfunction : next_chan
endpackage : tdm_sel_pkg

// File: tb/line_sink.sv
// receiver model on the high-speed line, with a stall pattern
module line_sink (
   input  wire logic clk_i,
   input  wire logic nrst_i,
   input  wire logic stall_i,
   output logic      ready_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] ph_ff;
   // free phase counter for the stall pattern
   always_ff @(posedge clk_i) begin
      if (!nrst_i) ph_ff <= 2'h0;
      else ph_ff <= ph_ff + 2'h1;
   end
   // ready only one cycle in four while stalling, so the buffer fills
   assign ready_o = nrst_i && (!stall_i || ph_ff == 2'h3);
endmodule : line_sink

// File: tb/tb_tdm_channel_selector.sv
// self-checking bench for the channel selector
module tb_tdm_channel_selector;
   timeunit 1ns;
   timeprecision 1ps;
   logic               clk_i = 1'b0;
   logic               nrst_i = 1'b0;
   logic               load = 1'b0;
   logic               mode = 1'b0;
   logic               stall = 1'b0;
   logic [4:0]         addr = 5'h00;
   logic [31:0]        pat = 32'h5a3c_96e1;
   logic               ready;
   logic               valid;
   tdm_sel_pkg::slot_t slot;
   tdm_sel_pkg::slot_t w;
   int                 n_fail = 0;
   int                 cmp_count = 0;

   always #2.5 clk_i = ~clk_i;

   tdm_channel_selector tdm_channel_selector_i (.clk_i(clk_i), .nrst_i(nrst_i),
      .chan_data_i(pat), .chan_addr_i(addr), .select_source_load_i(load),
      .char_mode_i(mode), .line_ready_i(ready), .line_valid_o(valid), .line_slot_o(slot));
   line_sink line_sink_i (.clk_i(clk_i), .nrst_i(nrst_i), .stall_i(stall), .ready_o(ready));

   // compare one value and count it
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   // wait, bounded, for the next word taken by the receiver
   task automatic take();
      for (int k = 0; k < 200; k++) begin
         @(posedge clk_i);
         if (valid === 1'b1 && ready === 1'b1) begin
            w = slot;
            return;
         end
      end
      n_fail++;
      $display("mismatch take expected word seen none");
   endtask : take

   // reset with the mode pins already settled
   task automatic restart(input logic m, input logic l);
      nrst_i <= 1'b0;
      mode   <= m;
      load   <= l;
      repeat (6) @(posedge clk_i);
      nrst_i <= 1'b1;
   endtask : restart

   // counter order over two cycles, bit slots, optional stall
   task automatic test_seq(input logic s);
      stall <= s;
      restart(1'b0, 1'b0);
      for (int i = 0; i < 64; i++) begin
         take();
         check("chan", w.chan, i[4:0]);
         check("first", w.first, 1'b1);
         check("data", w.data, pat[i % 32]);
      end
      stall <= 1'b0;
      $display("test seq done stall %0d", s);
   endtask : test_seq

   // character slots of eight bits per channel
   task automatic test_char();
      restart(1'b1, 1'b0);
      for (int i = 0; i < 80; i++) begin
         take();
         check("char chan", w.chan, 8'((i / 8) % 32));
         check("char first", w.first, i % 8 == 0);
         check("char data", w.data, pat[(i / 8) % 32]);
      end
      $display("test char done");
   endtask : test_char

   // external select, then counting on from the loaded code
   task automatic test_load();
      addr <= 5'h05;
      restart(1'b0, 1'b1);
      for (int i = 0; i < 4; i++) begin
         take();
         check("load chan", w.chan, 8'h05);
         check("load data", w.data, pat[5]);
      end
      load <= 1'b0;
      take();
      for (int k = 0; k < 8 && w.chan == 5'h05; k++) take();
      check("after load", w.chan, 8'h06);
      take();
      check("after load", w.chan, 8'h07);
      $display("test load done");
   endtask : test_load

   // verdict and end of run
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : finish_test

   // main sequence
   initial begin
      test_seq(1'b0);
      pat <= ~pat;
      test_seq(1'b1);
      test_char();
      test_load();
      finish_test();
   end

   // watchdog
   initial begin
      #100000;
      n_fail++;
      finish_test();
   end
endmodule : tb_tdm_channel_selector
